// File: dpld_pkg.sv
// Package for the dual loop lock detector: constants and carrier types
package dpld_pkg;

    localparam int            UNLOCK_WIN_PERIODS = 2;
    localparam int            LOCK_WIN_PERIODS   = 4;
    localparam int            LOCK_CYCLES        = 3;
    localparam int            ERR_W              = 8;
    localparam int            MIN_PULSE_CYCLES   = 1;
    localparam logic [1:0]    FSEL_REF_IF        = 2'h0;
    localparam logic [1:0]    FSEL_REF_RF        = 2'h1;
    localparam logic [1:0]    FSEL_CMP_IF        = 2'h2;
    localparam logic [1:0]    FSEL_CMP_RF        = 2'h3;

    // Comparator outputs of one section
    typedef struct packed {
        logic up_o;
        logic up_oe;
        logic dn_o;
        logic dn_oe;
    } dpld_pd_type;

    // Edge inputs of one section
    typedef struct packed {
        logic ref_edge;
        logic cmp_edge;
    } dpld_edges_type;

endpackage

// File: dpld_section.sv
// One section: phase-frequency comparator, error measure and lock qualifier
module dpld_section
    import dpld_pkg::*;
#(
    parameter int ERR_WIDTH = ERR_W
)
(
    input  wire logic           sys_clk,
    input  wire logic           reset,
    input  wire dpld_edges_type edges,
    input  wire logic           active,
    output dpld_pd_type         phase_det_out,
    output logic                locked_or_idle
);
    localparam logic [ERR_WIDTH-1:0] UNLOCK_CNT = ERR_WIDTH'(UNLOCK_WIN_PERIODS);
    localparam logic [ERR_WIDTH-1:0] LOCK_CNT   = ERR_WIDTH'(LOCK_WIN_PERIODS);
    localparam logic [ERR_WIDTH-1:0] ERR_MAX    = {ERR_WIDTH{1'b1}};

    // Elaboration check: the counter must hold the lock window
    if (ERR_WIDTH < 4)
    begin
        $error("ERR_WIDTH too small for lock windows");
    end

    logic                 up_reg;
    logic                 dn_reg;
    logic                 done_reg;
    logic [ERR_WIDTH-1:0] err_reg;
    logic [1:0]           good_reg;
    logic                 lock_reg;
    logic                 oe_reg;
    logic                 up_set;
    logic                 dn_set;
    logic                 both;

    ////////////////////////////////////////////////////////////////////////
    // Tri-state comparator
    // Up and down flags each track one edge, so errors up to a full cycle either way register
    assign up_set = up_reg | edges.ref_edge;
    assign dn_set = dn_reg | edges.cmp_edge;
    assign both   = up_set & dn_set;

    // Minimum pulse width
    // Both flags stay set one cycle before clearing, giving a pulse even at zero error
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
        end
        else if (!active || (up_reg & dn_reg))
        begin
            up_reg <= edges.ref_edge & active;
            dn_reg <= edges.cmp_edge & active;
        end
        else
        begin
            up_reg <= up_set;
            dn_reg <= dn_set;
        end
    end

    // Undriven in power saving
    // Enable moves on the edge that clears the flags, so no pulse is ever shown undriven
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            oe_reg <= 1'b0;
        else
            oe_reg <= active;
    end

    always_comb
    begin
        phase_det_out.up_o  = up_reg;
        phase_det_out.dn_o  = dn_reg;
        phase_det_out.up_oe = oe_reg;
        phase_det_out.dn_oe = oe_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Error width in oscillator periods
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            err_reg <= '0;
        else if (!active || (up_reg & dn_reg))
            err_reg <= '0;
        else if ((up_reg ^ dn_reg) && err_reg != ERR_MAX)
            err_reg <= err_reg + 1'b1;
    end

    assign done_reg = up_reg & dn_reg;

    ////////////////////////////////////////////////////////////////////////
    // Lock qualifier; power saving counts as locked
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            good_reg <= 2'h0;
            lock_reg <= 1'b0;
        end
        else if (!active)
        begin
            good_reg <= 2'h0;
            lock_reg <= 1'b0;
        end
        else if ((up_reg ^ dn_reg) && err_reg + 1'b1 >= UNLOCK_CNT && err_reg + 1'b1 > LOCK_CNT)
        begin
            good_reg <= 2'h0;
            lock_reg <= 1'b0;
        end
        else if (done_reg)
        begin
            if (err_reg > LOCK_CNT)
                good_reg <= 2'h0;
            else if (good_reg == 2'(LOCK_CYCLES - 1))
                lock_reg <= 1'b1;
            else
                good_reg <= good_reg + 2'h1;
        end
    end

    assign locked_or_idle = lock_reg | !active;
endmodule

// File: dpld_top.sv
// Dual loop lock detector top: pin synchronisers, two sections, shared output pin
module dpld_top
(
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic                 power_save_n,
    input  wire logic                 lockpin_select,
    input  wire logic [1:0]           fout_select,
    input  wire logic                 ref_if,
    input  wire logic                 cmp_if,
    input  wire logic                 ref_rf,
    input  wire logic                 cmp_rf,
    output dpld_pkg::dpld_pd_type     phase_det_out_if,
    output dpld_pkg::dpld_pd_type     phase_det_out_rf,
    output logic                      lock_detect_out
);
    import dpld_pkg::*;

    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [3:0] prev_reg;
    logic       lk_if;
    logic       lk_rf;
    logic       fsel;
    logic       out_reg;
    logic [2:0] sel_sync1_reg;
    logic [2:0] sel_sync2_reg;
    dpld_edges_type e_if;
    dpld_edges_type e_rf;

    ////////////////////////////////////////////////////////////////////////
    // Pins come from outside the clock domain
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            prev_reg  <= 4'h0;
            sel_sync1_reg <= 3'h0;
            sel_sync2_reg <= 3'h0;
        end
        else
        begin
            sync1_reg <= {power_save_n, ref_if, cmp_if, ref_rf, cmp_rf};
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg[3:0];
            // Select bits are static settings; a mixed word while they change only disturbs the pin for a cycle
            sel_sync1_reg <= {lockpin_select, fout_select};
            sel_sync2_reg <= sel_sync1_reg;
        end
    end

    assign e_if = '{ref_edge: sync2_reg[3] & ~prev_reg[3], cmp_edge: sync2_reg[2] & ~prev_reg[2]};
    assign e_rf = '{ref_edge: sync2_reg[1] & ~prev_reg[1], cmp_edge: sync2_reg[0] & ~prev_reg[0]};

    ////////////////////////////////////////////////////////////////////////
    // Power saving while low
    // Both sections share one control; the host cannot idle one section alone this way
    dpld_section u_if
    (
        .sys_clk        (sys_clk),
        .reset          (reset),
        .edges          (e_if),
        .active         (sync2_reg[4]),
        .phase_det_out  (phase_det_out_if),
        .locked_or_idle (lk_if)
    );

    dpld_section u_rf
    (
        .sys_clk        (sys_clk),
        .reset          (reset),
        .edges          (e_rf),
        .active         (sync2_reg[4]),
        .phase_det_out  (phase_det_out_rf),
        .locked_or_idle (lk_rf)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        case (sel_sync2_reg[1:0])
            FSEL_REF_IF: fsel = sync2_reg[3];
            FSEL_REF_RF: fsel = sync2_reg[1];
            FSEL_CMP_IF: fsel = sync2_reg[2];
            default:     fsel = sync2_reg[0];
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            out_reg <= 1'b0;
        else if (!sel_sync2_reg[2])
            out_reg <= lk_if & lk_rf;
        else
            out_reg <= fsel;
    end

    assign lock_detect_out = out_reg;
endmodule

// File: dpld_sva.sv
// Port-level assertions for the dual loop lock detector
module dpld_sva
    import dpld_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        power_save_n,
    input wire logic        lockpin_select,
    input wire dpld_pd_type phase_det_out_if,
    input wire dpld_pd_type phase_det_out_rf,
    input wire logic        lock_detect_out,
    input wire logic        ref_if,
    input wire logic        cmp_rf
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////
    // A flag may restart only from a pin edge that reached the section as the pair ended
    property p_end_if;
        phase_det_out_if.up_o && phase_det_out_if.dn_o
            |=> !phase_det_out_if.up_o || ($past(ref_if, 3) && !$past(ref_if, 4));
    endproperty
    a_end_if: assert property (p_end_if) else $error("IF pulse pair too long");
    property p_end_rf;
        phase_det_out_rf.up_o && phase_det_out_rf.dn_o
            |=> !phase_det_out_rf.dn_o || ($past(cmp_rf, 3) && !$past(cmp_rf, 4));
    endproperty
    a_end_rf: assert property (p_end_rf) else $error("RF pulse pair too long");
    property p_up_if; phase_det_out_if.up_o |-> phase_det_out_if.up_oe; endproperty
    a_up_if: assert property (p_up_if) else $error("IF up pulse undriven");
    property p_dn_rf; phase_det_out_rf.dn_o |-> phase_det_out_rf.dn_oe; endproperty
    a_dn_rf: assert property (p_dn_rf) else $error("RF down pulse undriven");
    // Five cycles cover the two-stage synchroniser plus the enable register
    property p_hiz_if; !power_save_n [*5] |-> !phase_det_out_if.up_oe && !phase_det_out_if.dn_oe; endproperty
    a_hiz_if: assert property (p_hiz_if) else $error("IF driven in power saving");
    property p_hiz_rf; !power_save_n [*5] |-> !phase_det_out_rf.up_oe && !phase_det_out_rf.dn_oe; endproperty
    a_hiz_rf: assert property (p_hiz_rf) else $error("RF driven in power saving");
    property p_ps_lock; (!power_save_n && !lockpin_select) [*8] |-> lock_detect_out; endproperty
    a_ps_lock: assert property (p_ps_lock) else $error("lock low in power saving");
    // Both pins pass two flip-flops and the output register before they reach the pin
    property p_pin_fall; $fell(lock_detect_out) |-> $past(power_save_n, 3) || $past(lockpin_select, 3); endproperty
    a_pin_fall: assert property (p_pin_fall) else $error("lock fell while idle");
endmodule
bind dpld_top dpld_sva dpld_sva_i (.sys_clk, .reset, .power_save_n, .lockpin_select,
    .phase_det_out_if, .phase_det_out_rf, .lock_detect_out, .ref_if, .cmp_rf);

// File: dpld_host.sv
// Host model: runs the power-save control of the synthesizer
module dpld_host
(
    input  wire logic sys_clk,
    input  wire logic run_req,
    output logic      power_save_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial power_save_n = 1'h0;
    always @(posedge sys_clk)
        power_save_n <= #1 run_req;
endmodule

// File: dpld_top_tb.sv
// Testbench for the dual loop lock detector
module dpld_top_tb;
    import dpld_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin bad_count++; $display("ERROR %s expected %0h seen %0h", n, e, a); end end
    logic        sys_clk, reset, run_req, power_save_n, lockpin_select, lock_detect_out;
    logic        ref_if, cmp_if, ref_rf, cmp_rf;
    logic [1:0]  fout_select;
    dpld_pd_type pd_if, pd_rf;
    int          bad_count, check_count, both_pulses;
    dpld_top dpld_top_i (.sys_clk(sys_clk), .reset(reset), .power_save_n(power_save_n),
        .lockpin_select(lockpin_select), .fout_select(fout_select), .ref_if(ref_if), .cmp_if(cmp_if),
        .ref_rf(ref_rf), .cmp_rf(cmp_rf), .phase_det_out_if(pd_if), .phase_det_out_rf(pd_rf),
        .lock_detect_out(lock_detect_out));
    dpld_host dpld_host_i (.sys_clk(sys_clk), .run_req(run_req), .power_save_n(power_save_n));
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        if (pd_if.up_o && pd_if.dn_o) both_pulses++;
    ////////////////////////////////////////////////////////////////
    task finish_test;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // One comparison per section, cmp edge n cycles after ref edge
    task comp(input int ni, input int nr);
        for (int i = 0; i < 16; i++)
        begin
            ref_if = (i < 4);
            ref_rf = (i < 4);
            cmp_if = (i >= ni) && (i < ni + 4);
            cmp_rf = (i >= nr) && (i < nr + 4);
            step(1);
        end
    endtask
    task t_idle;
        `CHK("lock_idle", 1'h1, lock_detect_out)
        `CHK("oe_idle", 1'h0, pd_if.up_oe | pd_rf.dn_oe)
    endtask
    task t_partial;
        run_req = 1'h1;
        step(8);
        `CHK("oe_run", 1'h1, pd_if.dn_oe & pd_rf.up_oe)
        repeat (4) comp(2, 99);
        `CHK("lock_rf_open", 1'h0, lock_detect_out)
    endtask
    // The first pair also closes the RF up flag left open by the previous scenario
    task t_lock;
        both_pulses = 0;
        comp(0, 2);
        `CHK("zero_err_pulse", 1, both_pulses)
        repeat (2) comp(2, 2);
        `CHK("lock_two", 1'h0, lock_detect_out)
        comp(2, 2);
        `CHK("lock_three", 1'h1, lock_detect_out)
    endtask
    task t_restart;
        comp(8, 2);
        `CHK("unlock_wide", 1'h0, lock_detect_out)
        repeat (2) comp(2, 2);
        `CHK("relock_two", 1'h0, lock_detect_out)
        comp(2, 2);
        `CHK("relock_three", 1'h1, lock_detect_out)
    endtask
    task t_select;
        lockpin_select = 1'h1;
        fout_select = FSEL_REF_IF;
        step(8);
        `CHK("fout_low", 1'h0, lock_detect_out)
        ref_if = 1'h1;
        step(8);
        `CHK("fout_ref_if", 1'h1, lock_detect_out)
        fout_select = FSEL_REF_RF;
        step(8);
        `CHK("fout_ref_rf", 1'h0, lock_detect_out)
        cmp_if = 1'h1;
        fout_select = FSEL_CMP_IF;
        step(8);
        `CHK("fout_cmp_if", 1'h1, lock_detect_out)
        fout_select = FSEL_CMP_RF;
        step(8);
        `CHK("fout_cmp_rf", 1'h0, lock_detect_out)
    endtask
    task t_ps;
        run_req = 1'h0;
        lockpin_select = 1'h0;
        step(10);
        `CHK("lock_ps", 1'h1, lock_detect_out)
        `CHK("oe_ps", 1'h0, pd_if.dn_oe | pd_rf.up_oe)
    endtask
    initial
    begin
        #120000;
        bad_count++;
        finish_test;
    end
    initial
    begin
        {sys_clk, run_req, lockpin_select, ref_if, cmp_if, ref_rf, cmp_rf} = 7'h00;
        fout_select = 2'h0;
        reset = 1'h1;
        step(12);
        reset = 1'h0;
        step(10);
        t_idle;
        t_partial;
        t_lock;
        t_restart;
        t_select;
        t_ps;
        finish_test;
    end
endmodule
